// ==== src/eiw_params.svh ====
`ifndef EIW_PARAMS_SVH
`define EIW_PARAMS_SVH

// register byte addresses
`define EIW_OFS_CTRL 8'h00
`define EIW_OFS_FLAG 8'h04
`define EIW_OFS_CORE 8'h08
`define EIW_OFS_EVT_STATUS 8'h0c
`define EIW_OFS_EVT_MASK 8'h10
`define EIW_OFS_SHADOW_BASE 8'h80
`define EIW_SHADOW_BANK 31

// control register fields
`define EIW_CTRL_GIE_BIT 0
`define EIW_CTRL_EXT_EN_BIT 1
`define EIW_CTRL_EDGE_BIT 2
`define EIW_CTRL_PERIPH_LSB 8

// flag register field
`define EIW_FLAG_EXT_BIT 0

// core state register fields
`define EIW_CORE_HALT_BIT 0
`define EIW_CORE_HANDLER_BIT 1
`define EIW_CORE_STEP_BIT 2

// event status and mask fields
`define EIW_EVT_EDGE_BIT 0
`define EIW_EVT_WAKE_BIT 1
`define EIW_EVT_ENTRY_BIT 2
`define EIW_EVT_RETURN_BIT 3
`define EIW_EVT_W 4

// reset values
`define EIW_GIE_RST 1'b0
`define EIW_EXT_EN_RST 1'b0
`define EIW_EDGE_RST 1'b1
`define EIW_EVT_MASK_RST 4'h0

// status bits that go into the shadow copy
`define EIW_STATUS_SAVE_MASK 8'he7

// shadow bank size in bytes
`define EIW_SHADOW_N 8

`endif

// ==== src/eiw_pkg.sv ====
package eiw_pkg;

	// context bytes, index 0 (w) at the top
	typedef struct packed {
		logic [7:0] w;
		logic [7:0] status;
		logic [7:0] bank_select_reg;
		logic [7:0] fsr0l;
		logic [7:0] fsr0h;
		logic [7:0] fsr1l;
		logic [7:0] fsr1h;
		logic [7:0] pc_high_latch;
	} eiw_ctx_type;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_HALT,
		ST_WAKE_STEP,
		ST_HANDLER
	} eiw_state_type;

endpackage

// ==== src/eiw_edge_detect.sv ====
`timescale 1ns/1ps
module eiw_edge_detect (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	input wire logic rise_sel_i,
	output logic edge_o
);
	logic prev_q;
	logic valid_q;

	// first sample after reset is only a reference, never an edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			prev_q <= pin_i;
			valid_q <= 1'b1;
		end
	end

	assign edge_o = valid_q & (rise_sel_i ? (pin_i & ~prev_q)
		: (~pin_i & prev_q));

endmodule // eiw_edge_detect

// ==== src/eiw_shadow_bank.sv ====
`timescale 1ns/1ps
`include "eiw_params.svh"
module eiw_shadow_bank
	import eiw_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic save_i,
	input eiw_ctx_type save_ctx_i,
	input wire logic wr_i,
	input wire logic [2:0] wr_idx_i,
	input wire logic [7:0] wr_byte_i,
	output eiw_ctx_type shadow_o
);
	logic [7:0] mem_q [`EIW_SHADOW_N];

	genvar i;
	generate
		for (i = 0; i < `EIW_SHADOW_N; i++) begin : g_byte
			// entry copy wins over a software write
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					mem_q[i] <= 8'h00;
				end else if (save_i) begin
					mem_q[i] <= save_ctx_i[63-8*i -: 8];
				end else if (wr_i && wr_idx_i == 3'(i)) begin
					mem_q[i] <= wr_byte_i;
				end
			end
			assign shadow_o[63-8*i -: 8] = mem_q[i];
		end
	endgenerate

endmodule // eiw_shadow_bank

// ==== src/eiw_top.sv ====
`timescale 1ns/1ps
`include "eiw_params.svh"
module eiw_top
	import eiw_pkg::*;
#(
	parameter int PC_W = 15,
	parameter int PERIPH_N = 8,
	parameter logic [7:0] CLOCKLESS_MASK = 8'h01
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_pin_i,
	input wire logic [PERIPH_N-1:0] periph_irq_i,
	input wire logic halt_i,
	input wire logic instr_done_i,
	input wire logic ret_i,
	input wire logic [PC_W-1:0] pc_i,
	input eiw_ctx_type live_ctx_i,
	output logic core_sleep_o,
	output logic wake_o,
	output logic vector_o,
	output logic push_o,
	output logic [PC_W-1:0] push_pc_o,
	output logic restore_o,
	output eiw_ctx_type restore_ctx_o,
	output logic irq_o
);
	generate
		if (PC_W < 8 || PC_W > 16) begin : g_bad_pc
			$error("eiw_top: PC_W must be 8 to 16");
		end
		if (PERIPH_N < 1 || PERIPH_N > 8) begin : g_bad_periph
			$error("eiw_top: PERIPH_N must be 1 to 8");
		end
	endgenerate

	eiw_state_type state_q, state_d;
	logic gie_q, ext_en_q, edge_sel_q, flag_q, ack_q;
	logic [PERIPH_N-1:0] periph_en_q;
	logic [`EIW_EVT_W-1:0] evt_status_q, evt_mask_q, evt_set;
	logic [31:0] dat_q, rd_data;
	logic wake_q, vector_q, push_q, restore_q;
	logic [PC_W-1:0] push_pc_q;
	eiw_ctx_type restore_ctx_q, shadow_ctx, save_ctx;
	logic ext_edge, req, wr_en, rd_en, shadow_hit, shadow_wr;
	logic [2:0] shadow_idx;
	logic ext_pending, periph_pending, wake_cond, entry_go, ret_go, flag_clr;

	// bus decode; writes and read-clears act on the ack edge
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_en = req & wb_we_i & ack_q & wb_sel_i[0];
	assign rd_en = req & ~wb_we_i & ack_q;
	assign shadow_hit = wb_adr_i[7] & (wb_adr_i[6:5] == 2'b00)
		& (wb_adr_i[1:0] == 2'b00);
	assign shadow_idx = wb_adr_i[4:2];
	assign shadow_wr = wr_en & shadow_hit;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	eiw_edge_detect u_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(ext_pin_i),
		.rise_sel_i(edge_sel_q),
		.edge_o(ext_edge)
	);

	// status keeps the two power bits out
	always_comb begin
		save_ctx = live_ctx_i;
		save_ctx.status = live_ctx_i.status & `EIW_STATUS_SAVE_MASK;
	end

	eiw_shadow_bank u_shadow (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.save_i(entry_go),
		.save_ctx_i(save_ctx),
		.wr_i(shadow_wr),
		.wr_idx_i(shadow_idx),
		.wr_byte_i(wb_dat_i[7:0]),
		.shadow_o(shadow_ctx)
	);

	assign ext_pending = flag_q & ext_en_q;
	assign periph_pending = |(periph_irq_i & periph_en_q);
	assign wake_cond = ext_pending
		| (|(periph_irq_i & periph_en_q & CLOCKLESS_MASK[PERIPH_N-1:0]));
	assign flag_clr = wr_en & (wb_adr_i == `EIW_OFS_FLAG)
		& wb_dat_i[`EIW_FLAG_EXT_BIT];

	// entry only on an instruction boundary
	always_comb begin
		entry_go = 1'b0;
		if (gie_q && (ext_pending || periph_pending) && instr_done_i) begin
			entry_go = (state_q == ST_RUN) || (state_q == ST_WAKE_STEP);
		end
	end
	assign ret_go = (state_q == ST_HANDLER) & ret_i;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_RUN: begin
				if (entry_go) begin
					state_d = ST_HANDLER;
				end else if (halt_i) begin
					state_d = ST_HALT;
				end
			end
			ST_HALT: begin
				if (wake_cond) begin
					state_d = ST_WAKE_STEP;
				end
			end
			ST_WAKE_STEP: begin
				if (entry_go) begin
					state_d = ST_HANDLER;
				end else if (instr_done_i) begin
					state_d = ST_RUN;
				end
			end
			ST_HANDLER: begin
				if (ret_i) begin
					state_d = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// flag sticky, a new edge wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else if (ext_edge) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// control register; entry and return override software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gie_q <= `EIW_GIE_RST;
			ext_en_q <= `EIW_EXT_EN_RST;
			edge_sel_q <= `EIW_EDGE_RST;
			periph_en_q <= '0;
		end else begin
			if (wr_en && wb_adr_i == `EIW_OFS_CTRL) begin
				gie_q <= wb_dat_i[`EIW_CTRL_GIE_BIT];
				ext_en_q <= wb_dat_i[`EIW_CTRL_EXT_EN_BIT];
				edge_sel_q <= wb_dat_i[`EIW_CTRL_EDGE_BIT];
				if (wb_sel_i[1]) begin
					periph_en_q <=
						wb_dat_i[`EIW_CTRL_PERIPH_LSB +: PERIPH_N];
				end
			end
			if (entry_go) begin
				gie_q <= 1'b0;
			end else if (ret_go) begin
				gie_q <= 1'b1;
			end
		end
	end

	// event status: set wins over read-clear
	assign evt_set = {ret_go, entry_go, wake_q, ext_edge};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_status_q <= '0;
		end else if (rd_en && wb_adr_i == `EIW_OFS_EVT_STATUS) begin
			evt_status_q <= evt_set;
		end else begin
			evt_status_q <= evt_status_q | evt_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_mask_q <= `EIW_EVT_MASK_RST;
		end else if (wr_en && wb_adr_i == `EIW_OFS_EVT_MASK) begin
			evt_mask_q <= wb_dat_i[`EIW_EVT_W-1:0];
		end
	end

	// core-facing pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_q <= 1'b0;
			vector_q <= 1'b0;
			push_q <= 1'b0;
			push_pc_q <= '0;
			restore_q <= 1'b0;
			restore_ctx_q <= '0;
		end else begin
			wake_q <= (state_q == ST_HALT) & wake_cond;
			// return address goes to the stack
			vector_q <= entry_go;
			push_q <= entry_go;
			if (entry_go) begin
				push_pc_q <= pc_i;
			end
			// restore from shadow, handler edits are lost
			restore_q <= ret_go;
			if (ret_go) begin
				restore_ctx_q <= shadow_ctx;
			end
		end
	end

	// read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		if (shadow_hit) begin
			rd_data[7:0] = shadow_ctx[63-8*shadow_idx -: 8];
		end else begin
			unique case (wb_adr_i)
				`EIW_OFS_CTRL: begin
					rd_data[`EIW_CTRL_GIE_BIT] = gie_q;
					rd_data[`EIW_CTRL_EXT_EN_BIT] = ext_en_q;
					rd_data[`EIW_CTRL_EDGE_BIT] = edge_sel_q;
					rd_data[`EIW_CTRL_PERIPH_LSB +: 8] = 8'(periph_en_q);
				end
				`EIW_OFS_FLAG: begin
					rd_data[`EIW_FLAG_EXT_BIT] = flag_q;
				end
				`EIW_OFS_CORE: begin
					rd_data[`EIW_CORE_HALT_BIT] = state_q == ST_HALT;
					rd_data[`EIW_CORE_HANDLER_BIT] = state_q == ST_HANDLER;
					rd_data[`EIW_CORE_STEP_BIT] = state_q == ST_WAKE_STEP;
				end
				`EIW_OFS_EVT_STATUS: begin
					rd_data[`EIW_EVT_W-1:0] = evt_status_q;
				end
				`EIW_OFS_EVT_MASK: begin
					rd_data[`EIW_EVT_W-1:0] = evt_mask_q;
				end
				default: begin
					rd_data = 32'h0000_0000;
				end
			endcase
		end
	end

	// data captured with the ack so it stands while ack is high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (req && !ack_q) begin
			dat_q <= rd_data;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign core_sleep_o = state_q == ST_HALT;
	assign wake_o = wake_q;
	assign vector_o = vector_q;
	assign push_o = push_q;
	assign push_pc_o = push_pc_q;
	assign restore_o = restore_q;
	assign restore_ctx_o = restore_ctx_q;
	assign irq_o = |(evt_status_q & evt_mask_q);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_flag_on_edge: assert property (
		ext_edge |=> flag_q
	) else $error("flag not set after valid edge");
	chk_flag_sticky: assert property (
		flag_q && !flag_clr |=> flag_q
	) else $error("flag dropped without a clear");
	chk_edge_polarity: assert property (
		ext_edge |-> (edge_sel_q ? ext_pin_i : !ext_pin_i)
	) else $error("edge of wrong polarity accepted");

	chk_vector_gate: assert property (
		vector_q |-> $past(gie_q) && ($past(ext_pending)
			|| $past(periph_pending))
	) else $error("vector without enables and pending source");

	chk_push_pc: assert property (
		vector_q |-> push_q && push_pc_q == $past(pc_i)
	) else $error("return pc not pushed on entry");
	chk_wake_source: assert property (
		wake_q |-> $past(state_q) == ST_HALT && $past(ext_pending
			|| |(periph_irq_i & periph_en_q
			& CLOCKLESS_MASK[PERIPH_N-1:0]))
	) else $error("wake from a source that cannot run clockless");
	chk_step_first: assert property (
		wake_q |-> !vector_q ##1 (!vector_q || $past(instr_done_i))
	) else $error("vector before the step after halt");

	chk_resume_inline: assert property (
		state_q == ST_WAKE_STEP && instr_done_i && !gie_q
			|=> state_q == ST_RUN && !vector_q
	) else $error("no inline resume with global enable clear");

	chk_save_ctx: assert property (
		entry_go |=> shadow_ctx.w == $past(live_ctx_i.w)
			&& shadow_ctx.status == ($past(live_ctx_i.status)
			& `EIW_STATUS_SAVE_MASK)
			&& shadow_ctx.pc_high_latch == $past(live_ctx_i.pc_high_latch)
	) else $error("context not copied on entry");
	chk_restore_ctx: assert property (
		restore_q |-> restore_ctx_q == $past(shadow_ctx)
	) else $error("restore data differs from shadow");
	chk_shadow_write: assert property (
		shadow_wr && !entry_go |=>
			shadow_ctx[63-8*$past(shadow_idx) -: 8] == $past(wb_dat_i[7:0])
	) else $error("shadow write not stored");

	cov_wake_vector: cover property (
		wake_q ##[1:20] vector_q
	);
	cov_wake_inline: cover property (
		state_q == ST_WAKE_STEP ##1 state_q == ST_RUN
	);
	cov_entry_return: cover property (
		vector_q ##[1:50] restore_q
	);
	cov_flag_clear_race: cover property (
		ext_edge && flag_clr
	);

endmodule // eiw_top

// ==== verification/eiw_core_model.sv ====
`timescale 1ns/1ps
module eiw_core_model
	import eiw_pkg::*;
#(
	parameter int PC_W = 15
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic halt_req_i,
	input wire logic ret_req_i,
	input wire logic wake_i,
	output logic halt_o,
	output logic instr_done_o,
	output logic ret_o,
	output logic [PC_W-1:0] pc_o,
	output eiw_ctx_type live_ctx_o,
	output logic [PC_W-1:0] snap_pc_o,
	output eiw_ctx_type snap_ctx_o
);
	logic sleep_q;
	logic [7:0] tick_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sleep_q <= 1'h0;
			tick_q <= 8'h00;
			halt_o <= 1'h0;
			ret_o <= 1'h0;
			instr_done_o <= 1'h0;
			pc_o <= '0;
			live_ctx_o <= '0;
		end else begin
			halt_o <= halt_req_i;
			ret_o <= ret_req_i;
			if (halt_req_i) begin
				sleep_q <= 1'h1;
			end else if (wake_i) begin
				sleep_q <= 1'h0;
			end
			instr_done_o <= !halt_req_i && (!sleep_q || wake_i);
			if (instr_done_o) begin
				pc_o <= pc_o + 1'h1;
			end
			tick_q <= tick_q + 8'h01;
			// live regs drift in handler; status bits 4,3 kept high
			live_ctx_o <= {8{tick_q}} ^ 64'h5a18_3c00_0000_0000
				| 64'h0018_0000_0000_0000;
		end
		snap_pc_o <= pc_o;
		snap_ctx_o <= live_ctx_o;
	end
endmodule // eiw_core_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`include "eiw_params.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench
	import eiw_pkg::*;
;
	logic clk_i;
	logic rst_i = 1'h1;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0, pin = 1'h0;
	logic halt_req = 1'h0, ret_req = 1'h0;
	logic [7:0] adr = 8'h00, pirq = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat, q;
	logic ack, sleep, wake, vec, push, rest, irq, halt, idone, ret, hit;
	logic [14:0] pc, push_pc, snap_pc;
	eiw_ctx_type live, rctx, snap_ctx, exp_ctx;
	int num_errors = 0, tests_run = 0, cycles = 0, steps, k;
	eiw_top i_eiw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_pin_i(pin),
		.periph_irq_i(pirq), .halt_i(halt), .instr_done_i(idone),
		.ret_i(ret), .pc_i(pc), .live_ctx_i(live), .core_sleep_o(sleep),
		.wake_o(wake), .vector_o(vec), .push_o(push), .push_pc_o(push_pc),
		.restore_o(rest), .restore_ctx_o(rctx), .irq_o(irq));
	eiw_core_model i_eiw_core_model (.clk_i(clk_i), .rst_i(rst_i),
		.halt_req_i(halt_req), .ret_req_i(ret_req), .wake_i(wake),
		.halt_o(halt), .instr_done_o(idone), .ret_o(ret), .pc_o(pc),
		.live_ctx_o(live), .snap_pc_o(snap_pc), .snap_ctx_o(snap_ctx));
	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		// no cycle limit here; the bench timeout ends a hang
		do begin
			@(posedge clk_i);
		end while (ack !== 1'h1);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d, 4'hf);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		bus(1'h0, a, 32'h0, 4'hf);
		`CHK(nm, e, q)
	endtask
	task automatic pin_to(input logic v);
		@(posedge clk_i);
		pin <= v;
	endtask
	task automatic settle();
		repeat (4) @(posedge clk_i);
	endtask
	task automatic pulse_halt();
		@(posedge clk_i);
		halt_req <= 1'h1;
		@(posedge clk_i);
		halt_req <= 1'h0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic pulse_ret();
		@(posedge clk_i);
		ret_req <= 1'h1;
		@(posedge clk_i);
		ret_req <= 1'h0;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return vec;
			1: return wake;
			default: return rest;
		endcase
	endfunction
	// samples at negedge; stops in the cycle the pulse stands
	task automatic waitfor(input int s, input int lim);
		hit = 1'h0;
		steps = 0;
		for (int i = 0; i < lim && hit !== 1'h1; i++) begin
			@(negedge clk_i);
			hit = pick(s);
			if (hit !== 1'h1 && idone === 1'h1) steps++;
		end
	endtask
	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask
	task report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// run is about 250 cycles; generous ceiling
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		rdc(`EIW_OFS_CTRL, 32'h4, "ctrl");
		rdc(`EIW_OFS_FLAG, 32'h0, "flag");
		rdc(`EIW_OFS_EVT_MASK, 32'h0, "mask");
		rdc(8'h40, 32'h0, "unmapped");
		bus(1'h1, `EIW_OFS_CTRL, 32'h3, 4'he);
		rdc(`EIW_OFS_CTRL, 32'h4, "sel0 low");
		tdone("reset");
		// k=0 rising, k=1 falling; idle level is the inactive edge end
		for (k = 0; k < 2; k++) begin
			wr(`EIW_OFS_CTRL, k == 0 ? 32'h4 : 32'h0);
			pin_to(k[0]);
			settle();
			wr(`EIW_OFS_FLAG, 32'h1);
			pin_to(!k[0]);
			settle();
			rdc(`EIW_OFS_FLAG, 32'h1, "flag set");
			pin_to(k[0]);
			pin_to(!k[0]);
			settle();
			rdc(`EIW_OFS_FLAG, 32'h1, "flag held");
			wr(`EIW_OFS_FLAG, 32'h1);
			pin_to(k[0]);
			settle();
			rdc(`EIW_OFS_FLAG, 32'h0, "wrong edge");
		end
		tdone("edges");
		@(negedge clk_i);
		`CHK("irq masked", 1'h0, irq)
		wr(`EIW_OFS_EVT_MASK, 32'h1);
		@(negedge clk_i);
		`CHK("irq", 1'h1, irq)
		rdc(`EIW_OFS_EVT_STATUS, 32'h1, "status");
		rdc(`EIW_OFS_EVT_STATUS, 32'h0, "status clr");
		@(negedge clk_i);
		`CHK("irq clr", 1'h0, irq)
		tdone("irq");
		wr(`EIW_OFS_CTRL, 32'h1);
		pin_to(1'h0);
		waitfor(0, 12);
		`CHK("no vector", 1'h0, hit)
		wr(`EIW_OFS_CTRL, 32'h3);
		waitfor(0, 12);
		`CHK("vector", 1'h1, hit)
		`CHK("push", 1'h1, push)
		`CHK("push pc", snap_pc, push_pc)
		exp_ctx = snap_ctx;
		exp_ctx.status = exp_ctx.status & `EIW_STATUS_SAVE_MASK;
		rdc(8'h84, {24'h0, exp_ctx.status}, "shadow st");
		wr(`EIW_OFS_FLAG, 32'h1);
		wr(`EIW_OFS_SHADOW_BASE, 32'h5a);
		exp_ctx.w = 8'h5a;
		rdc(`EIW_OFS_SHADOW_BASE, 32'h5a, "shadow w");
		pulse_ret();
		waitfor(2, 12);
		`CHK("restore", 1'h1, hit)
		`CHK("restore ctx", exp_ctx, rctx)
		tdone("entry");
		wr(`EIW_OFS_CTRL, 32'h2);
		pin_to(1'h1);
		pulse_halt();
		@(negedge clk_i);
		`CHK("sleep", 1'h1, sleep)
		rdc(`EIW_OFS_CORE, 32'h1, "core halted");
		pin_to(1'h0);
		waitfor(1, 12);
		`CHK("wake", 1'h1, hit)
		waitfor(0, 12);
		`CHK("resume", 1'h0, hit)
		wr(`EIW_OFS_FLAG, 32'h1);
		wr(`EIW_OFS_CTRL, 32'h3);
		pin_to(1'h1);
		pulse_halt();
		pin_to(1'h0);
		waitfor(1, 12);
		waitfor(0, 12);
		`CHK("wake vector", 1'h1, hit)
		`CHK("step first", 1'h1, steps > 0)
		rdc(`EIW_OFS_CORE, 32'h2, "in handler");
		wr(`EIW_OFS_FLAG, 32'h1);
		pulse_ret();
		waitfor(2, 12);
		tdone("wake");
		wr(`EIW_OFS_CTRL, 32'h300);
		pulse_halt();
		@(posedge clk_i);
		pirq <= 8'h02;
		waitfor(1, 12);
		`CHK("clocked src", 1'h0, hit)
		@(posedge clk_i);
		pirq <= 8'h03;
		waitfor(1, 12);
		`CHK("clockless src", 1'h1, hit)
		@(posedge clk_i);
		pirq <= 8'h00;
		rdc(`EIW_OFS_EVT_STATUS, 32'hf, "all events");
		rdc(`EIW_OFS_EVT_STATUS, 32'h0, "events clr");
		tdone("periph");
		report_and_stop();
	end
endmodule // testbench
